/* File: design/sdo_consts.svh */
// Constants of the synthesizer divider and output register bank:
// register indices, field slices, reset values and fixed bit images.
// Assumes it is included by its bare name wherever it is needed.
`ifndef SDO_CONSTS_SVH
`define SDO_CONSTS_SVH

// Register indices; the byte address is four times the index
`define SDO_IDX_FBDIV_HI 6'h22
`define SDO_IDX_FBDIV_LO 6'h24
`define SDO_IDX_SEED_PFD 6'h25
`define SDO_IDX_DEN_HI 6'h26
`define SDO_IDX_DEN_LO 6'h27
`define SDO_IDX_SEED_HI 6'h28
`define SDO_IDX_SEED_LO 6'h29
`define SDO_IDX_NUM_HI 6'h2a
`define SDO_IDX_NUM_LO 6'h2b
`define SDO_IDX_OUTA_MOD 6'h2c
`define SDO_IDX_OUTA_SEL 6'h2d
`define SDO_IDX_OUTB_SEL 6'h2e
`define SDO_IDX_STATUS 6'h30
`define SDO_IDX_ACC_HI 6'h31
`define SDO_IDX_ACC_LO 6'h32
`define SDO_IDX_PIN_CFG 6'h3a

// Field slices within their 16-bit register
`define SDO_F_FBDIV_HI 2:0
`define SDO_F_SEED_EN 15
`define SDO_F_PFD 13:8
`define SDO_F_OUTPUT_A_POWER 13:8
`define SDO_F_OUTPUT_B_POWERDOWN 7
`define SDO_F_OUTPUT_A_POWERDOWN 6
`define SDO_F_MOD_RSTN 5
`define SDO_F_MOD_ORDER 2:0
`define SDO_F_OUTPUT_A_SOURCE_SELECT 12:11
`define SDO_F_ISET 10:9
`define SDO_F_OUTPUT_B_POWER 5:0
`define SDO_F_OUTPUT_B_SOURCE_SELECT 1:0
`define SDO_F_PIN_IGN 15
`define SDO_F_PIN_HYST 14
`define SDO_F_PIN_LVL 13:12
`define SDO_F_PIN_FMT 11:9

// Reset values
`define SDO_RST_FBDIV 19'h0_0064
`define SDO_RST_PFD 6'h02
`define SDO_RST_DEN 32'hFFFF_FFFF
`define SDO_RST_NUM 32'h0000_0000
`define SDO_RST_SEED 32'h0000_0000
`define SDO_RST_PWR 6'h1F
`define SDO_RST_MUX 2'h1
`define SDO_RST_ISET 2'h0
`define SDO_RST_ORDER 3'h0
`define SDO_RST_PIN_LVL 2'h0
`define SDO_RST_PIN_FMT 3'h0

// Fixed bit images, ORed into the read value
`define SDO_FIX_SEED_PFD 16'h0004
`define SDO_FIX_OUTA_SEL 16'h80C0
`define SDO_FIX_OUTB_SEL 16'h07FC
`define SDO_FIX_PIN_CFG 16'h0001

// Limits of legal codes
`define SDO_ORDER_MAX 3'h4
`define SDO_FMT_MAX 3'h3
`define SDO_LVL_BAD 2'h3

`endif

/* File: design/sdo_out_path.sv */
// One RF output path: resolves source select and power-down.
// Assumes the alternate-source enable comes from elsewhere in the chip.
`timescale 1ns/1ps
`default_nettype none
module sdo_out_path (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [1:0] select_i,
	input wire logic powerdown_i,
	input wire logic alt_enable_i,
	output sdo_pkg::sdo_source_type source_o,
	output logic active_o
);
	import sdo_pkg::*;

	wire sdo_source_type sel_src;
	wire alt_ok;
	wire next_active;

	assign sel_src = sdo_source_type'(select_i);
	// Alternate source is dead unless its generator is enabled
	assign alt_ok = (sel_src != SDO_SRC_ALT) | alt_enable_i;
	assign next_active = ~powerdown_i & (sel_src != SDO_SRC_HIZ) & alt_ok;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			source_o <= SDO_SRC_VCO;
			active_o <= 1'b0;
		end else begin
			source_o <= sel_src;
			active_o <= next_active;
		end
	end
endmodule // sdo_out_path
`default_nettype wire

/* File: design/sdo_pkg.sv */
// Types shared by the synthesizer register bank modules.
// Assumes nothing of its surroundings.
package sdo_pkg;

	typedef enum logic [1:0] {
		SDO_SRC_CHDIV = 2'h0,
		SDO_SRC_VCO = 2'h1,
		SDO_SRC_ALT = 2'h2,
		SDO_SRC_HIZ = 2'h3
	} sdo_source_type;

	typedef enum logic [2:0] {
		SDO_ORD_INTEGER = 3'h0,
		SDO_ORD_FIRST = 3'h1,
		SDO_ORD_SECOND = 3'h2,
		SDO_ORD_THIRD = 3'h3,
		SDO_ORD_FOURTH = 3'h4
	} sdo_order_type;

	// Byte-lane merge of a 16-bit register image
	function automatic logic [15:0] sdo_merge16(input logic [15:0] cur,
		input logic [15:0] nw, input logic [1:0] sel);
		sdo_merge16 = {sel[1] ? nw[15:8] : cur[15:8],
			sel[0] ? nw[7:0] : cur[7:0]};
	endfunction

endpackage

/* File: design/sdo_regs.sv */
// Configuration register bank of a fractional-N synthesizer: feedback
// divider, fraction, modulator and RF output controls.
// Assumes a classic Wishbone master on clk_i, 32-bit data, 16-bit regs.
`timescale 1ns/1ps
`default_nettype none
`include "sdo_consts.svh"
module sdo_regs (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic doubler_enable_i,
	input wire logic sysref_generator_enable_i,
	input wire logic phase_sync_mode_i,
	output logic [18:0] feedback_divider_o,
	output logic [5:0] phase_detector_delay_select_o,
	output logic [31:0] fraction_numerator_o,
	output logic [31:0] fraction_denominator_o,
	output logic [31:0] applied_seed_o,
	output logic modulator_run_o,
	output sdo_pkg::sdo_order_type modulator_order_o,
	output logic [5:0] output_a_power_o,
	output logic [5:0] output_b_power_o,
	output logic [1:0] output_current_boost_o,
	output sdo_pkg::sdo_source_type output_a_source_o,
	output sdo_pkg::sdo_source_type output_b_source_o,
	output logic output_a_active_o,
	output logic output_b_active_o,
	output logic sync_pins_enable_o,
	output logic input_high_hysteresis_o,
	output logic [1:0] lvds_bias_level_o,
	output logic [2:0] input_pin_format_o
);
	import sdo_pkg::*;

	logic [2:0] feedback_divider_high;
	logic [15:0] feedback_divider_low;
	logic seed_apply_enable;
	logic [5:0] phase_detector_delay_select;
	logic [31:0] fraction_denominator;
	logic [31:0] fraction_numerator;
	logic [31:0] modulator_seed;
	logic [5:0] output_a_power;
	logic output_b_powerdown;
	logic output_a_powerdown;
	logic modulator_reset_low;
	logic [2:0] modulator_order;
	logic [1:0] output_a_source_select;
	logic [1:0] output_current_boost;
	logic [5:0] output_b_power;
	logic [1:0] output_b_source_select;
	logic pin_ignore;
	logic input_high_hysteresis;
	logic [1:0] lvds_bias_level;
	logic [2:0] input_pin_format;
	logic [31:0] seed_acc;

	// Bus decode
	wire [5:0] idx;
	wire access;
	wire wr;
	wire [15:0] wr_data;
	wire [15:0] rd_word;
	wire hit_fb_hi, hit_fb_lo, hit_seed_pfd, hit_den_hi, hit_den_lo;
	wire hit_seed_hi, hit_seed_lo, hit_num_hi, hit_num_lo;
	wire hit_outa_mod, hit_outa_sel, hit_outb_sel, hit_pin;
	wire hit_status, hit_acc_hi, hit_acc_lo;
	wire [15:0] img_fb_hi, img_fb_lo, img_seed_pfd, img_outa_mod;
	wire [15:0] img_outa_sel, img_outb_sel, img_pin, img_status;
	wire order_reserved;
	wire fmt_invalid;
	wire lvl_invalid;
	wire seed_add;
	wire [31:0] seed_add_value;

	assign idx = adr_i[7:2];
	// One-cycle ack; masking access while ack_o is high stops a double hit
	assign access = cyc_i & stb_i & ~ack_o;
	assign wr = access & we_i;

	assign hit_fb_hi = idx == `SDO_IDX_FBDIV_HI;
	assign hit_fb_lo = idx == `SDO_IDX_FBDIV_LO;
	assign hit_seed_pfd = idx == `SDO_IDX_SEED_PFD;
	assign hit_den_hi = idx == `SDO_IDX_DEN_HI;
	assign hit_den_lo = idx == `SDO_IDX_DEN_LO;
	assign hit_seed_hi = idx == `SDO_IDX_SEED_HI;
	assign hit_seed_lo = idx == `SDO_IDX_SEED_LO;
	assign hit_num_hi = idx == `SDO_IDX_NUM_HI;
	assign hit_num_lo = idx == `SDO_IDX_NUM_LO;
	assign hit_outa_mod = idx == `SDO_IDX_OUTA_MOD;
	assign hit_outa_sel = idx == `SDO_IDX_OUTA_SEL;
	assign hit_outb_sel = idx == `SDO_IDX_OUTB_SEL;
	assign hit_pin = idx == `SDO_IDX_PIN_CFG;
	assign hit_status = idx == `SDO_IDX_STATUS;
	assign hit_acc_hi = idx == `SDO_IDX_ACC_HI;
	assign hit_acc_lo = idx == `SDO_IDX_ACC_LO;

	assign img_fb_hi = {13'h0000, feedback_divider_high};
	assign img_fb_lo = feedback_divider_low;
	assign img_seed_pfd = {seed_apply_enable, 1'b0,
		phase_detector_delay_select, 8'h00} | `SDO_FIX_SEED_PFD;
	assign img_outa_mod = {2'h0, output_a_power, output_b_powerdown,
		output_a_powerdown, modulator_reset_low, 2'h0, modulator_order};
	assign img_outa_sel = {3'h0, output_a_source_select,
		output_current_boost, 3'h0, output_b_power} | `SDO_FIX_OUTA_SEL;
	assign img_outb_sel = {14'h0000, output_b_source_select}
		| `SDO_FIX_OUTB_SEL;
	assign img_pin = {pin_ignore, input_high_hysteresis, lvds_bias_level,
		input_pin_format, 9'h000} | `SDO_FIX_PIN_CFG;
	assign img_status = {9'h000, ~pin_ignore, lvl_invalid, fmt_invalid,
		output_b_active_o, output_a_active_o, order_reserved,
		modulator_reset_low};

	// Unmapped indices read as zero
	assign rd_word = ({16{hit_fb_hi}} & img_fb_hi)
		| ({16{hit_fb_lo}} & img_fb_lo)
		| ({16{hit_seed_pfd}} & img_seed_pfd)
		| ({16{hit_den_hi}} & fraction_denominator[31:16])
		| ({16{hit_den_lo}} & fraction_denominator[15:0])
		| ({16{hit_seed_hi}} & modulator_seed[31:16])
		| ({16{hit_seed_lo}} & modulator_seed[15:0])
		| ({16{hit_num_hi}} & fraction_numerator[31:16])
		| ({16{hit_num_lo}} & fraction_numerator[15:0])
		| ({16{hit_outa_mod}} & img_outa_mod)
		| ({16{hit_outa_sel}} & img_outa_sel)
		| ({16{hit_outb_sel}} & img_outb_sel)
		| ({16{hit_pin}} & img_pin)
		| ({16{hit_status}} & img_status)
		| ({16{hit_acc_hi}} & seed_acc[31:16])
		| ({16{hit_acc_lo}} & seed_acc[15:0]);

	// Byte lanes 2 and 3 carry nothing; the upper half is ignored
	assign wr_data = sdo_merge16(rd_word, dat_i[15:0], sel_i[1:0]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= access;
			dat_o <= access ? {16'h0000, rd_word} : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			feedback_divider_high <= 3'(`SDO_RST_FBDIV >> 16);
			feedback_divider_low <= 16'(`SDO_RST_FBDIV);
		end else if (wr & hit_fb_hi) begin
			feedback_divider_high <= wr_data[`SDO_F_FBDIV_HI];
		end else if (wr & hit_fb_lo) begin
			feedback_divider_low <= wr_data;
		end
	end

	// seed enable, plus the delay select
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seed_apply_enable <= 1'b0;
			phase_detector_delay_select <= `SDO_RST_PFD;
		end else if (wr & hit_seed_pfd) begin
			seed_apply_enable <= wr_data[`SDO_F_SEED_EN];
			phase_detector_delay_select <= wr_data[`SDO_F_PFD];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fraction_denominator <= `SDO_RST_DEN;
		end else if (wr & hit_den_hi) begin
			fraction_denominator[31:16] <= wr_data;
		end else if (wr & hit_den_lo) begin
			fraction_denominator[15:0] <= wr_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fraction_numerator <= `SDO_RST_NUM;
		end else if (wr & hit_num_hi) begin
			fraction_numerator[31:16] <= wr_data;
		end else if (wr & hit_num_lo) begin
			fraction_numerator[15:0] <= wr_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			modulator_seed <= `SDO_RST_SEED;
		end else if (wr & hit_seed_hi) begin
			modulator_seed[31:16] <= wr_data;
		end else if (wr & hit_seed_lo) begin
			modulator_seed[15:0] <= wr_data;
		end
	end

	assign seed_add = wr & hit_seed_lo;
	assign seed_add_value = {modulator_seed[31:16], wr_data};

	sdo_seed_acc u_seed_acc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(~modulator_reset_low),
		.add_i(seed_add),
		.add_value_i(seed_add_value),
		.acc_o(seed_acc)
	);

	// output A power, both output power-downs and modulator control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			output_a_power <= `SDO_RST_PWR;
			output_b_powerdown <= 1'b1;
			output_a_powerdown <= 1'b0;
			modulator_reset_low <= 1'b1;
			modulator_order <= `SDO_RST_ORDER;
		end else if (wr & hit_outa_mod) begin
			output_a_power <= wr_data[`SDO_F_OUTPUT_A_POWER];
			output_b_powerdown <= wr_data[`SDO_F_OUTPUT_B_POWERDOWN];
			output_a_powerdown <= wr_data[`SDO_F_OUTPUT_A_POWERDOWN];
			modulator_reset_low <= wr_data[`SDO_F_MOD_RSTN];
			modulator_order <= wr_data[`SDO_F_MOD_ORDER];
		end
	end

	// output A select, boost, output B power
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			output_a_source_select <= `SDO_RST_MUX;
			output_current_boost <= `SDO_RST_ISET;
			output_b_power <= `SDO_RST_PWR;
		end else if (wr & hit_outa_sel) begin
			output_a_source_select <= wr_data[`SDO_F_OUTPUT_A_SOURCE_SELECT];
			output_current_boost <= wr_data[`SDO_F_ISET];
			output_b_power <= wr_data[`SDO_F_OUTPUT_B_POWER];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			output_b_source_select <= `SDO_RST_MUX;
		end else if (wr & hit_outb_sel) begin
			output_b_source_select <= wr_data[`SDO_F_OUTPUT_B_SOURCE_SELECT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_ignore <= 1'b1;
			input_high_hysteresis <= 1'b0;
			lvds_bias_level <= `SDO_RST_PIN_LVL;
			input_pin_format <= `SDO_RST_PIN_FMT;
		end else if (wr & hit_pin) begin
			pin_ignore <= wr_data[`SDO_F_PIN_IGN];
			input_high_hysteresis <= wr_data[`SDO_F_PIN_HYST];
			lvds_bias_level <= wr_data[`SDO_F_PIN_LVL];
			input_pin_format <= wr_data[`SDO_F_PIN_FMT];
		end
	end

	assign order_reserved = modulator_order > `SDO_ORDER_MAX;
	assign fmt_invalid = input_pin_format > `SDO_FMT_MAX;
	assign lvl_invalid = lvds_bias_level == `SDO_LVL_BAD;

	sdo_out_path u_out_a (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.select_i(output_a_source_select),
		.powerdown_i(output_a_powerdown),
		.alt_enable_i(doubler_enable_i),
		.source_o(output_a_source_o),
		.active_o(output_a_active_o)
	);

	sdo_out_path u_out_b (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.select_i(output_b_source_select),
		.powerdown_i(output_b_powerdown),
		.alt_enable_i(sysref_generator_enable_i),
		.source_o(output_b_source_o),
		.active_o(output_b_active_o)
	);

	// Registered view of the effective settings for the analog side
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			applied_seed_o <= `SDO_RST_SEED;
			modulator_run_o <= 1'b1;
			modulator_order_o <= SDO_ORD_INTEGER;
			sync_pins_enable_o <= 1'b0;
		end else begin
			applied_seed_o <= seed_apply_enable ? seed_acc : `SDO_RST_SEED;
			modulator_run_o <= modulator_reset_low;
			modulator_order_o <= (modulator_reset_low & ~order_reserved)
				? sdo_order_type'(modulator_order) : SDO_ORD_INTEGER;
			sync_pins_enable_o <= ~pin_ignore & phase_sync_mode_i
				& ~fmt_invalid & ~lvl_invalid;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			feedback_divider_o <= `SDO_RST_FBDIV;
			phase_detector_delay_select_o <= `SDO_RST_PFD;
			fraction_numerator_o <= `SDO_RST_NUM;
			fraction_denominator_o <= `SDO_RST_DEN;
		end else begin
			feedback_divider_o <= {feedback_divider_high,
				feedback_divider_low};
			phase_detector_delay_select_o <= phase_detector_delay_select;
			fraction_numerator_o <= modulator_reset_low
				? fraction_numerator : `SDO_RST_NUM;
			fraction_denominator_o <= fraction_denominator;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			output_a_power_o <= `SDO_RST_PWR;
			output_b_power_o <= `SDO_RST_PWR;
			output_current_boost_o <= `SDO_RST_ISET;
			input_high_hysteresis_o <= 1'b0;
			lvds_bias_level_o <= `SDO_RST_PIN_LVL;
			input_pin_format_o <= `SDO_RST_PIN_FMT;
		end else begin
			output_a_power_o <= output_a_power;
			output_b_power_o <= output_b_power;
			output_current_boost_o <= output_current_boost;
			input_high_hysteresis_o <= input_high_hysteresis;
			lvds_bias_level_o <= lvds_bias_level;
			input_pin_format_o <= input_pin_format;
		end
	end
endmodule // sdo_regs
`default_nettype wire

/* File: design/sdo_seed_acc.sv */
// Accumulating modulator seed.
// Assumes add strobes are one-cycle pulses in the clk_i domain.
`timescale 1ns/1ps
`default_nettype none
`include "sdo_consts.svh"
module sdo_seed_acc (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic add_i,
	input wire logic [31:0] add_value_i,
	output logic [31:0] acc_o
);
	import sdo_pkg::*;

	wire [31:0] next_acc;

	assign next_acc = acc_o + add_value_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_o <= `SDO_RST_SEED;
		end else if (clear_i) begin
			acc_o <= `SDO_RST_SEED;
		end else if (add_i) begin
			acc_o <= next_acc;
		end
	end
endmodule // sdo_seed_acc
`default_nettype wire

/* File: sim/sdo_regs_chk_sva.sv */
// Concurrent checks on the synthesizer register bank.
// Assumes it is bound to sdo_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module sdo_regs_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic doubler_enable_i,
	input wire logic [31:0] fraction_numerator_o,
	input wire logic [31:0] applied_seed_o,
	input wire logic modulator_run_o,
	input wire sdo_pkg::sdo_order_type modulator_order_o,
	input wire sdo_pkg::sdo_source_type output_a_source_o,
	input wire logic output_a_active_o,
	input wire logic sync_pins_enable_o,
	input wire logic [1:0] lvds_bias_level_o,
	input wire logic [2:0] input_pin_format_o
);
	import sdo_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack one cycle after request");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(ack_o) |-> $past(stb_i) && $past(cyc_i))
		else $error("ack without request");
	a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	a_dat_upper: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_frac_held: assert property (!modulator_run_o |->
		fraction_numerator_o == 32'h0000_0000 &&
		modulator_order_o == SDO_ORD_INTEGER)
		else $error("fraction used while modulator held");
	a_order_legal: assert property (
		modulator_order_o <= SDO_ORD_FOURTH)
		else $error("reserved order reached output");
	// Clearing needs a cycle to land and another to reach the output
	a_seed_cleared: assert property (
		(!modulator_run_o) [*3] |-> applied_seed_o == 32'h0000_0000)
		else $error("seed kept while modulator held");
	a_a_hiz_idle: assert property (
		output_a_source_o == SDO_SRC_HIZ |-> !output_a_active_o)
		else $error("output a active at high impedance");
	a_a_alt_gate: assert property (
		output_a_source_o == SDO_SRC_ALT && !doubler_enable_i &&
		!$past(doubler_enable_i) && !$past(doubler_enable_i, 2)
		|-> !output_a_active_o)
		else $error("doubler source active without enable");
	a_pins_valid: assert property (sync_pins_enable_o |->
		input_pin_format_o <= 3'h3 && lvds_bias_level_o != 2'h3)
		else $error("sync pins used with invalid format");

	c_write: cover property (ack_o && we_i);
	c_read: cover property (ack_o && !we_i);
	c_held: cover property ((!modulator_run_o) [*3]);
endmodule // sdo_regs_chk
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the synthesizer register bank.
// Assumes a single Wishbone master at 100 MHz and no far-side model.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sdo_pkg::*;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, e;
	logic [7:0] adr_i;
	logic [3:0] sel_i, k;
	logic [31:0] dat_i, dat_o, rd, st1, st2;
	logic doubler_enable_i, sysref_generator_enable_i, phase_sync_mode_i;
	logic [18:0] feedback_divider_o;
	logic [5:0] phase_detector_delay_select_o, output_a_power_o;
	logic [5:0] output_b_power_o;
	logic [31:0] fraction_numerator_o, fraction_denominator_o;
	logic [31:0] applied_seed_o;
	logic modulator_run_o, output_a_active_o, output_b_active_o;
	logic sync_pins_enable_o, input_high_hysteresis_o;
	logic [1:0] output_current_boost_o, lvds_bias_level_o;
	logic [2:0] input_pin_format_o;
	sdo_order_type modulator_order_o;
	sdo_source_type output_a_source_o, output_b_source_o;
	int num_errors, tests_run, i;
	logic [5:0] ridx [15] = '{6'h22, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28,
		6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h2e, 6'h3a, 6'h30, 6'h23};
	logic [15:0] rval [15] = '{16'h0000, 16'h0064, 16'h0204, 16'hFFFF,
		16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h1FA0,
		16'h88DF, 16'h07FD, 16'h8001, 16'h0005, 16'h0000};
	logic [5:0] widx [7] = '{6'h22, 6'h25, 6'h2d, 6'h2e, 6'h3a, 6'h31,
		6'h23};
	logic [15:0] wval [7] = '{16'h0007, 16'hBF04, 16'h9EFF, 16'h07FF,
		16'hFE01, 16'h0000, 16'h0000};

	sdo_regs i_sdo_regs (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .doubler_enable_i,
		.sysref_generator_enable_i, .phase_sync_mode_i, .feedback_divider_o,
		.phase_detector_delay_select_o, .fraction_numerator_o,
		.fraction_denominator_o, .applied_seed_o, .modulator_run_o,
		.modulator_order_o, .output_a_power_o, .output_b_power_o,
		.output_current_boost_o, .output_a_source_o, .output_b_source_o,
		.output_a_active_o, .output_b_active_o, .sync_pins_enable_o,
		.input_high_hysteresis_o, .lvds_bias_level_o, .input_pin_format_o);

	// Packed output images keep each comparison to one line
	assign st1 = {feedback_divider_o, phase_detector_delay_select_o,
		output_a_power_o, output_a_active_o};
	assign st2 = {output_b_power_o, output_current_boost_o,
		output_a_source_o, output_b_source_o, modulator_run_o,
		output_b_active_o, sync_pins_enable_o, input_high_hysteresis_o,
		lvds_bias_level_o, input_pin_format_o, modulator_order_o, 8'h00};

	task automatic chk(input logic [31:0] got, input logic [31:0] ev,
		input string what);
		tests_run++;
		if (got !== ev) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, ev);
		end
	endtask

	task automatic wb(input logic w, input logic [5:0] idx,
		input logic [15:0] d, input logic [1:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= {idx, 2'h0};
		sel_i <= {2'h0, s};
		dat_i <= {16'h0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'h1);
		rd = dat_o;
		// Ack follows the taking edge by one cycle; the watchdog ends a hang
		chk(n, 32'h0000_0002, "ack latency");
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		we_i <= 1'h0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		wb(1'h1, idx, d, 2'h3);
	endtask

	task automatic rc(input logic [5:0] idx, input logic [15:0] ev);
		wb(1'h0, idx, 16'h0000, 2'h3);
		chk(rd, {16'h0000, ev}, $sformatf("read %h", idx));
	endtask

	// Outputs trail their register by one clock
	task automatic settle;
		@(posedge clk_i);
		#1;
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		test_done;
	end

	initial begin
		rst_i = 1'h1;
		cyc_i = 1'h0;
		stb_i = 1'h0;
		we_i = 1'h0;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h0000_0000;
		doubler_enable_i = 1'h0;
		sysref_generator_enable_i = 1'h0;
		phase_sync_mode_i = 1'h0;
		num_errors = 0;
		tests_run = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		for (i = 0; i < 15; i++) rc(ridx[i], rval[i]);
		chk(st1, {19'h0_0064, 6'h02, 6'h1F, 1'h1}, "rst1");
		chk(st2, {6'h1F, 2'h0, 2'h1, 2'h1, 4'h8, 2'h0, 3'h0, 3'h0, 8'h00},
			"rst2");
		chk(fraction_denominator_o, 32'hFFFF_FFFF, "den");
		chk(applied_seed_o, 32'h0000_0000, "seed");
		$display("test reset done");
		for (i = 0; i < 7; i++) begin
			wr(widx[i], 16'hFFFF);
			rc(widx[i], wval[i]);
		end
		settle;
		chk(st1, {19'h7_0064, 6'h3F, 6'h1F, 1'h0}, "fix1");
		chk(st2, {6'h3F, 2'h3, 2'h3, 2'h3, 4'h9, 2'h3, 3'h7, 3'h0, 8'h00},
			"fix2");
		$display("test fixed done");
		wr(6'h22, 16'h0005);
		wr(6'h24, 16'hA5A5);
		wb(1'h1, 6'h24, 16'h1234, 2'h1);
		rc(6'h24, 16'hA534);
		wr(6'h25, 16'h8504);
		wr(6'h26, 16'h1234);
		wr(6'h27, 16'h5678);
		wr(6'h2a, 16'h8765);
		wr(6'h2b, 16'h4321);
		settle;
		chk(st1, {19'h5_A534, 6'h05, 6'h1F, 1'h0}, "divider");
		chk(fraction_denominator_o, 32'h1234_5678, "den");
		chk(fraction_numerator_o, 32'h8765_4321, "num");
		$display("test divider done");
		wr(6'h28, 16'h0001);
		wr(6'h29, 16'h0002);
		wr(6'h28, 16'h0000);
		wr(6'h29, 16'hFFFF);
		rc(6'h31, 16'h0002);
		rc(6'h32, 16'h0001);
		rc(6'h29, 16'hFFFF);
		settle;
		chk(applied_seed_o, 32'h0002_0001, "seed sum");
		wr(6'h25, 16'h0504);
		settle;
		chk(applied_seed_o, 32'h0000_0000, "seed gated");
		rc(6'h31, 16'h0002);
		wr(6'h2c, 16'h1F83);
		wr(6'h29, 16'h0007);
		settle;
		chk(fraction_numerator_o, 32'h0000_0000, "num held");
		rc(6'h32, 16'h0000);
		wr(6'h2c, 16'h1FA3);
		wr(6'h25, 16'h8504);
		wr(6'h29, 16'h0003);
		wr(6'h29, 16'h0003);
		rc(6'h32, 16'h0006);
		settle;
		chk(fraction_numerator_o, 32'h8765_4321, "num run");
		chk(applied_seed_o, 32'h0000_0006, "seed again");
		for (i = 0; i < 8; i++) begin
			wr(6'h2c, 16'h1FA0 | 16'(i));
			settle;
			chk({29'h0000_0000, modulator_order_o}, (i < 5) ? i : 0,
				"order");
		end
		$display("test modulator done");
		wr(6'h2c, 16'h1F20);
		for (i = 0; i < 8; i++) begin
			k = 4'(i);
			@(posedge clk_i);
			doubler_enable_i <= k[2];
			sysref_generator_enable_i <= k[2];
			wr(6'h2d, {3'h4, k[1:0], k[1:0], 1'h0, 2'h3, 6'h2A});
			wr(6'h2e, {14'h01FF, k[1:0]});
			settle;
			e = k[1:0] != 2'h3 && (k[1:0] != 2'h2 || k[2]);
			chk({18'h0_0000, output_a_active_o, output_b_active_o,
				output_a_source_o, output_b_source_o, output_current_boost_o,
				output_b_power_o}, {18'h0_0000, e, e, k[1:0], k[1:0],
				k[1:0], 6'h2A}, "out path");
		end
		wr(6'h2d, 16'h88C0);
		wr(6'h2e, 16'h07FD);
		wr(6'h2c, 16'h0A60);
		settle;
		chk({24'h00_0000, output_a_power_o, output_a_active_o,
			output_b_active_o}, {24'h00_0000, 6'h0A, 2'h1}, "pd");
		wr(6'h2c, 16'h1FA0);
		settle;
		chk({24'h00_0000, output_a_power_o, output_a_active_o,
			output_b_active_o}, {24'h00_0000, 6'h1F, 2'h2}, "pd");
		$display("test outputs done");
		for (i = 0; i < 16; i++) begin
			k = 4'(i);
			@(posedge clk_i);
			phase_sync_mode_i <= (i != 0);
			wr(6'h3a, {2'h0, k[3:2], k[2:0], 9'h001});
			settle;
			e = i != 0 && k[2:0] <= 3'h3 && k[3:2] != 2'h3;
			chk({26'h000_0000, sync_pins_enable_o, lvds_bias_level_o,
				input_pin_format_o}, {26'h000_0000, e, k[3:2], k[2:0]},
				"pins");
		end
		wr(6'h3a, 16'hC201);
		settle;
		chk({30'h0000_0000, sync_pins_enable_o, input_high_hysteresis_o},
			32'h0000_0001, "ignore");
		wr(6'h3a, 16'h4201);
		settle;
		chk({30'h0000_0000, sync_pins_enable_o, input_high_hysteresis_o},
			32'h0000_0003, "use pins");
		$display("test pins done");
		test_done;
	end
endmodule // tb

bind sdo_regs sdo_regs_chk i_sdo_regs_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
	.we_i, .dat_o, .ack_o, .doubler_enable_i, .fraction_numerator_o,
	.applied_seed_o, .modulator_run_o, .modulator_order_o,
	.output_a_source_o, .output_a_active_o, .sync_pins_enable_o,
	.lvds_bias_level_o, .input_pin_format_o);
`default_nettype wire
